// file: logic/swl_pkg.sv
// shared constants, types and timing for the single wire slave link
package swl_pkg;
	// ----------------------------------------
	// clock and timing, times in ns
	// ----------------------------------------
	localparam int CLK_MHZ         = 40;
	localparam int TMR_W           = 15;
	localparam int RESET_DETECT_NS = 400000;
	localparam int PRES_WAIT_NS    = 30000;
	localparam int PRES_LOW_NS     = 120000;
	localparam int FILTER_NS       = 250;
	localparam int HOLDOFF_NS      = 1000;
	localparam int WR_SAMPLE_NS    = 30000;
	localparam int RD_HOLD_NS      = 30000;

	// least time to cycles, rounded up, never below one
	function automatic int nsToCyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : nsToCyc

	localparam int RESET_DETECT_CYC = nsToCyc(RESET_DETECT_NS);
	localparam int PRES_WAIT_CYC    = nsToCyc(PRES_WAIT_NS);
	localparam int PRES_LOW_CYC     = nsToCyc(PRES_LOW_NS);
	localparam int FILTER_CYC       = nsToCyc(FILTER_NS);
	localparam int HOLDOFF_CYC      = nsToCyc(HOLDOFF_NS);
	localparam int WR_SAMPLE_CYC    = nsToCyc(WR_SAMPLE_NS);
	localparam int RD_HOLD_CYC      = nsToCyc(RD_HOLD_NS);

	// ----------------------------------------
	// command codes and crc
	// ----------------------------------------
	localparam logic [7:0]  CMD_SKIP    = 8'hcc;
	localparam logic [7:0]  CMD_RESUME  = 8'ha5;
	localparam logic [7:0]  CMD_MATCH   = 8'h55;
	localparam logic [7:0]  CMD_SEARCH  = 8'hf0;
	localparam logic [7:0]  CMD_READROM = 8'h33;
	localparam logic [15:0] CRC16_POLY  = 16'ha001;
	localparam logic [15:0] CRC16_INIT  = 16'h0000;
	localparam logic [7:0]  CRC8_POLY   = 8'h8c;
	localparam logic [5:0]  ROM_LAST    = 6'h3f;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {ROM_CMD, ROM_MATCH, ROM_SEARCH, ROM_READ,
		MEM_PHASE, WAIT_RESET} swl_rom_t;
	typedef enum logic [1:0] {PH_SLOTS, PH_WAIT_HIGH, PH_PRES_WAIT,
		PH_PRES_LOW} swl_phase_t;
	typedef struct packed {
		logic       isCrc;
		logic [7:0] data;
	} swl_tx_t;
endpackage : swl_pkg

// file: logic/swl_link.sv
// slave link layer: reset/presence, slots, rom selection, crc-16, rx buffer
// Notes on behaviour
// R1: skip command goes straight to memory phase
// R2: master uses skip only with one slave
// R3: resume enters memory phase while flag set
// R4: only match or search success sets flag
// R5: other device addressed clears resume flag
// R6: master makes all falls except presence
// R7: after reset rise wait, then pull low
// R8: master samples presence at its sample time
// R9: ready for slots right after presence sequence
// R10: mixed buses stretch reset high window
// R11: each slot carries exactly one bit
// R12: falling edge restarts slot timer
// R13: master honours write one and zero lows
// R14: recovery needed before next slot
// R15: read zero held low, read one undriven
// R16: master samples in window, waits slot
// R17: filter fall, ignore glitches in hold-off
// R18: rom top byte is crc-8 of rest
// R19: crc-16 polynomial, sent inverted
// R20: write path clears then accumulates crc
// R21: read path clears, accumulates sent data
// R22: match compares 64 bits, else wait reset
// R23: search sends bit, complement, reads choice
// R24: least significant bit first everywhere
// R25: master checks crc-16, repeats on error
module swl_link #(
	parameter int RESET_CYC    = swl_pkg::RESET_DETECT_CYC,
	parameter int PRES_LOW_CYC = swl_pkg::PRES_LOW_CYC
) (
	input  wire logic           sys_clk,
	input  wire logic           arst_n,
	input  wire logic           lineIn,     // wire level from pin
	output logic                lineOut,    // level driven, always low
	output logic                lineOe,     // high while pulling wire
	input  wire logic [63:0]    romCode,    // registration number
	output logic [7:0]          rxByte,     // received byte
	output logic                rxValid,
	input  wire logic           rxReady,
	input  wire swl_pkg::swl_tx_t txItem,   // byte or crc request
	input  wire logic           txValid,
	output logic                txReady,
	output logic                memActive,  // memory phase selected
	output logic                resumeFlag,
	output logic                romCrcOk    // rom crc byte consistent
);
	localparam logic [swl_pkg::TMR_W-1:0] TMR_MAX = '1;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic                      lineMeta_q, lineS_q, linePrev_q; // sync chain
	logic [swl_pkg::TMR_W-1:0] lowCnt_q;     // continuous low time
	logic [swl_pkg::TMR_W-1:0] holdoff_q;    // glitch ignore window
	logic [swl_pkg::TMR_W-1:0] tmr_q;        // slot and presence timer
	swl_pkg::swl_phase_t       phase_q;
	logic                      slotAct_q, slotRd_q, slotBit_q;
	logic                      drive_q;
	swl_pkg::swl_rom_t         romState_q;
	logic [5:0]                bitIdx_q;
	logic [1:0]                sub_q;        // search triplet step
	logic                      mism_q;
	logic [7:0]                rxShift_q;
	logic                      rxPend_q;     // full byte awaiting buffer
	logic                      resume_q;
	logic [15:0]               crc_q;
	logic [15:0]               txShift_q;
	logic [4:0]                txLeft_q;
	logic                      txCrc_q;
	swl_pkg::swl_tx_t          txHold_q;
	logic                      txHoldV_q, txHoldV_d, txReady_q;
	logic [7:0]                head_q, tail_q;
	logic                      headV_q, tailV_q;
	logic [7:0]                head_d, tail_d;
	logic                      headV_d, tailV_d;
	logic                      crcOk_q;
	logic                      resetHit, slotStart, bitDone, bitVal;
	logic                      readNow, readBit, txLoad, txTake, pushOk;
	logic [7:0]                cmdByte;

	// one lsb-first crc-16 step
	function automatic logic [15:0] crc16Bit(input logic [15:0] c, input logic b);
		return (c >> 1) ^ ((c[0] ^ b) ? swl_pkg::CRC16_POLY : 16'h0000); // R19 R24
	endfunction : crc16Bit

	// crc-8 over the low 56 rom bits, lsb first
	function automatic logic [7:0] crc8Rom(input logic [63:0] r);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			c = (c >> 1) ^ ((c[0] ^ r[i]) ? swl_pkg::CRC8_POLY : 8'h00);
		end
		return c;
	endfunction : crc8Rom

	// ----------------------------------------
	// line input and slot edge detection
	// ----------------------------------------
	// two-stage synchroniser, then a delayed copy for edge detection
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lineMeta_q <= 1'b1;
			lineS_q    <= 1'b1;
			linePrev_q <= 1'b1;
		end else begin
			lineMeta_q <= lineIn;
			lineS_q    <= lineMeta_q;
			linePrev_q <= lineS_q;
		end
	end

	// hold-off after each rise; low time only counts once it expires
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			holdoff_q <= '0;
			lowCnt_q  <= '0;
		end else begin
			if (lineS_q && !linePrev_q) begin
				holdoff_q <= swl_pkg::TMR_W'(swl_pkg::HOLDOFF_CYC); // R17
			end else if (holdoff_q != '0) begin
				holdoff_q <= holdoff_q - 1'b1;
			end
			if (lineS_q || holdoff_q != '0) begin
				lowCnt_q <= '0; // R17
			end else if (lowCnt_q != TMR_MAX) begin
				lowCnt_q <= lowCnt_q + 1'b1;
			end
		end
	end

	// low lasting the filter time starts a slot; very long low is reset
	assign resetHit  = lowCnt_q == swl_pkg::TMR_W'(RESET_CYC);
	assign slotStart = phase_q == swl_pkg::PH_SLOTS && // R17 R6
		lowCnt_q == swl_pkg::TMR_W'(swl_pkg::FILTER_CYC);
	assign bitDone = slotAct_q && tmr_q == (slotRd_q ? // R11
		swl_pkg::TMR_W'(swl_pkg::RD_HOLD_CYC - 1) :
		swl_pkg::TMR_W'(swl_pkg::WR_SAMPLE_CYC - 1));
	assign bitVal = slotRd_q ? slotBit_q : lineS_q;

	// ----------------------------------------
	// presence sequence, slot timer, pulldown
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q   <= swl_pkg::PH_SLOTS;
			tmr_q     <= '0;
			slotAct_q <= 1'b0;
			slotRd_q  <= 1'b0;
			slotBit_q <= 1'b1;
			drive_q   <= 1'b0;
		end else if (resetHit) begin
			phase_q   <= swl_pkg::PH_WAIT_HIGH;
			slotAct_q <= 1'b0;
			drive_q   <= 1'b0;
		end else begin
			case (phase_q)
				swl_pkg::PH_WAIT_HIGH: begin
					// presence wait begins at the rise
					if (lineS_q) begin
						phase_q <= swl_pkg::PH_PRES_WAIT;
						tmr_q   <= '0;
					end
				end
				swl_pkg::PH_PRES_WAIT: begin
					tmr_q <= tmr_q + 1'b1;
					if (tmr_q == swl_pkg::TMR_W'(swl_pkg::PRES_WAIT_CYC - 1)) begin
						phase_q <= swl_pkg::PH_PRES_LOW; // R7
						tmr_q   <= '0;
						drive_q <= 1'b1;
					end
				end
				swl_pkg::PH_PRES_LOW: begin
					tmr_q <= tmr_q + 1'b1;
					if (tmr_q == swl_pkg::TMR_W'(PRES_LOW_CYC - 1)) begin
						phase_q <= swl_pkg::PH_SLOTS; // R9
						drive_q <= 1'b0;
					end
				end
				swl_pkg::PH_SLOTS: begin
					if (slotStart) begin
						tmr_q     <= '0; // R12
						slotAct_q <= 1'b1;
						slotRd_q  <= readNow;
						slotBit_q <= readBit;
						drive_q   <= readNow && !readBit; // R15
					end else if (slotAct_q) begin
						tmr_q <= tmr_q + 1'b1;
						if (bitDone) begin
							// line left free for recovery before next fall
							slotAct_q <= 1'b0; // R14
							drive_q   <= 1'b0; // R15
						end
					end
				end
				default: phase_q <= swl_pkg::PH_SLOTS;
			endcase
		end
	end

	// ----------------------------------------
	// bit source for the coming slot
	// ----------------------------------------
	always_comb begin
		readNow = 1'b0;
		readBit = 1'b1;
		case (romState_q)
			swl_pkg::ROM_READ: begin
				readNow = 1'b1;
				readBit = romCode[bitIdx_q]; // R24
			end
			swl_pkg::ROM_SEARCH: begin
				readNow = sub_q != 2'd2; // R23
				readBit = romCode[bitIdx_q] ^ sub_q[0];
			end
			swl_pkg::MEM_PHASE: begin
				readNow = txLeft_q != 5'd0;
				readBit = txShift_q[0]; // R24
			end
			default: readNow = 1'b0;
		endcase
	end

	assign cmdByte = {bitVal, rxShift_q[7:1]};
	assign txLoad  = romState_q == swl_pkg::MEM_PHASE && txLeft_q == 5'd0 &&
		txHoldV_q && !slotAct_q && !slotStart;
	assign pushOk  = !tailV_q;

	// ----------------------------------------
	// rom functions, memory phase shifters, crc
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			romState_q <= swl_pkg::WAIT_RESET;
			bitIdx_q   <= '0;
			sub_q      <= '0;
			mism_q     <= 1'b0;
			rxShift_q  <= '0;
			rxPend_q   <= 1'b0;
			resume_q   <= 1'b0;
			crc_q      <= swl_pkg::CRC16_INIT;
			txShift_q  <= '1;
			txLeft_q   <= '0;
			txCrc_q    <= 1'b0;
		end else if (resetHit) begin
			romState_q <= swl_pkg::ROM_CMD;
			bitIdx_q   <= '0;
			txLeft_q   <= '0;
		end else begin
			if (rxPend_q && pushOk) begin
				rxPend_q <= 1'b0;
			end
			if (txLoad) begin
				// crc request sends the snapshot inverted, low byte first
				txCrc_q   <= txHold_q.isCrc;
				txShift_q <= txHold_q.isCrc ? ~crc_q : {8'hff, txHold_q.data}; // R19
				txLeft_q  <= txHold_q.isCrc ? 5'd16 : 5'd8;
			end
			if (bitDone) begin
				case (romState_q)
					swl_pkg::ROM_CMD: begin
						rxShift_q <= cmdByte;
						bitIdx_q  <= bitIdx_q + 1'b1;
						if (bitIdx_q == 6'd7) begin
							bitIdx_q <= '0;
							sub_q    <= '0;
							mism_q   <= 1'b0;
							crc_q    <= swl_pkg::CRC16_INIT; // R20 R21
							case (cmdByte)
								swl_pkg::CMD_SKIP: romState_q <= swl_pkg::MEM_PHASE; // R1
								swl_pkg::CMD_RESUME: romState_q <= resume_q ? // R3
									swl_pkg::MEM_PHASE : swl_pkg::WAIT_RESET;
								swl_pkg::CMD_MATCH:   romState_q <= swl_pkg::ROM_MATCH;
								swl_pkg::CMD_SEARCH:  romState_q <= swl_pkg::ROM_SEARCH;
								swl_pkg::CMD_READROM: romState_q <= swl_pkg::ROM_READ;
								default:              romState_q <= swl_pkg::WAIT_RESET;
							endcase
						end
					end
					swl_pkg::ROM_MATCH: begin
						bitIdx_q <= bitIdx_q + 1'b1;
						if (bitVal != romCode[bitIdx_q]) begin
							mism_q <= 1'b1; // R22
						end
						if (bitIdx_q == swl_pkg::ROM_LAST) begin
							if (mism_q || bitVal != romCode[bitIdx_q]) begin
								romState_q <= swl_pkg::WAIT_RESET; // R22
								resume_q   <= 1'b0; // R5
							end else begin
								romState_q <= swl_pkg::MEM_PHASE;
								resume_q   <= 1'b1; // R4
							end
						end
					end
					swl_pkg::ROM_SEARCH: begin
						sub_q <= sub_q + 1'b1;
						if (sub_q == 2'd2) begin
							sub_q    <= '0;
							bitIdx_q <= bitIdx_q + 1'b1;
							if (bitVal != romCode[bitIdx_q]) begin
								romState_q <= swl_pkg::WAIT_RESET; // R23
								resume_q   <= 1'b0; // R5
							end else if (bitIdx_q == swl_pkg::ROM_LAST) begin
								romState_q <= swl_pkg::MEM_PHASE;
								resume_q   <= 1'b1; // R4
							end
						end
					end
					swl_pkg::ROM_READ: begin
						bitIdx_q <= bitIdx_q + 1'b1;
						if (bitIdx_q == swl_pkg::ROM_LAST) begin
							romState_q <= swl_pkg::WAIT_RESET; // R18
						end
					end
					swl_pkg::MEM_PHASE: begin
						if (slotRd_q) begin
							// sent bits count unless they are the crc itself
							txShift_q <= {1'b1, txShift_q[15:1]};
							txLeft_q  <= txLeft_q - 1'b1;
							if (!txCrc_q) begin
								crc_q <= crc16Bit(crc_q, bitVal); // R21
							end
						end else if (!rxPend_q) begin
							// a stalled byte blocks the shifter; bits then drop
							crc_q     <= crc16Bit(crc_q, bitVal); // R20
							rxShift_q <= cmdByte;
							bitIdx_q  <= bitIdx_q + 1'b1;
							if (bitIdx_q[2:0] == 3'd7) begin
								rxPend_q <= 1'b1;
							end
						end
					end
					default: romState_q <= swl_pkg::WAIT_RESET;
				endcase
			end
		end
	end

	// ----------------------------------------
	// transmit holding register
	// ----------------------------------------
	assign txTake = txValid && txReady_q;

	always_comb begin
		txHoldV_d = txHoldV_q;
		if (resetHit || txLoad) begin
			txHoldV_d = 1'b0;
		end else if (txTake) begin
			txHoldV_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			txHold_q  <= '0;
			txHoldV_q <= 1'b0;
			txReady_q <= 1'b0;
		end else begin
			if (txTake) begin
				txHold_q <= txItem;
			end
			txHoldV_q <= txHoldV_d;
			txReady_q <= !txHoldV_d;
		end
	end

	// ----------------------------------------
	// two-entry receive buffer, head drives outputs
	// ----------------------------------------
	always_comb begin
		head_d  = head_q;
		tail_d  = tail_q;
		headV_d = headV_q;
		tailV_d = tailV_q;
		if (headV_q && rxReady) begin
			head_d  = tail_q;
			headV_d = tailV_q;
			tailV_d = 1'b0;
		end
		if (rxPend_q && pushOk) begin
			if (!headV_d) begin
				head_d  = rxShift_q;
				headV_d = 1'b1;
			end else begin
				tail_d  = rxShift_q;
				tailV_d = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			head_q  <= '0;
			tail_q  <= '0;
			headV_q <= 1'b0;
			tailV_q <= 1'b0;
		end else begin
			head_q  <= head_d;
			tail_q  <= tail_d;
			headV_q <= headV_d;
			tailV_q <= tailV_d;
		end
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			crcOk_q   <= 1'b0;
			memActive <= 1'b0;
			lineOut   <= 1'b0;
		end else begin
			crcOk_q   <= crc8Rom(romCode) == romCode[63:56]; // R18
			memActive <= romState_q == swl_pkg::MEM_PHASE;
			lineOut   <= 1'b0;
		end
	end

	assign lineOe     = drive_q;
	assign rxByte     = head_q;
	assign rxValid    = headV_q;
	assign txReady    = txReady_q;
	assign resumeFlag = resume_q;
	assign romCrcOk   = crcOk_q;
endmodule : swl_link

// file: logic/swl_link_dummy_note.sv
// holds no logic; the link, its buffers and its crc all sit in the main link module

// file: tb/swl_link_sva.sv
// port checker for the single wire slave link, bound into the link
module swl_link_chk #(
	parameter int RESET_CYC    = 16000,
	parameter int PRES_LOW_CYC = 4800
) (
	input wire logic             sys_clk,
	input wire logic             arst_n,
	input wire logic             lineIn,
	input wire logic             lineOut,
	input wire logic             lineOe,
	input wire logic [63:0]      romCode,
	input wire logic [7:0]       rxByte,
	input wire logic             rxValid,
	input wire logic             rxReady,
	input wire swl_pkg::swl_tx_t txItem,
	input wire logic             txValid,
	input wire logic             txReady,
	input wire logic             memActive,
	input wire logic             resumeFlag,
	input wire logic             romCrcOk
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	int   hiCnt_q;  // consecutive high samples of the wire
	int   lowCnt_q; // consecutive low samples of the wire
	int   oeCnt_q;  // cycles the device has pulled so far
	logic expOk;    // rom crc byte consistent with the rest
	// serial crc-8, lsb first, same order as the wire
	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++)
			c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
		return c;
	endfunction : crc8
	assign expOk = (crc8(romCode[55:0]) == romCode[63:56]);
	// ----------------------------------------
	// run-length counters of wire and drive
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hiCnt_q  <= 0;
			lowCnt_q <= 0;
			oeCnt_q  <= 0;
		end else begin
			hiCnt_q  <= lineIn ? hiCnt_q + 1 : 0;
			lowCnt_q <= lineIn ? 0 : lowCnt_q + 1;
			oeCnt_q  <= lineOe ? oeCnt_q + 1 : 0;
		end
	end
	// device pulls a line that was high: only the presence pulse may do so
	sequence s_presStart;
		$rose(lineOe) && hiCnt_q > 0;
	endsequence
	property p_presWait;
		s_presStart |-> hiCnt_q inside {[1199:1210]};
	endproperty
	a_presWait: assert property (p_presWait)
		else $error("presence pull not after the wait time");
	property p_presLen;
		$fell(lineOe) && !memActive && oeCnt_q < 1000 |-> oeCnt_q == PRES_LOW_CYC;
	endproperty
	a_presLen: assert property (p_presLen)
		else $error("presence pull of wrong length");
	property p_slotDrive;
		$rose(lineOe) && memActive |-> hiCnt_q == 0 && lowCnt_q inside {[10:20]};
	endproperty
	a_slotDrive: assert property (p_slotDrive)
		else $error("read drive not right after slot start");
	property p_readHold;
		$fell(lineOe) && memActive |-> oeCnt_q inside {[1190:1205]};
	endproperty
	a_readHold: assert property (p_readHold)
		else $error("read zero held for wrong time");
	property p_outLow;
		lineOe |-> lineOut == 1'b0;
	endproperty
	a_outLow: assert property (p_outLow)
		else $error("device drives the wire high");
	property p_wireReset;
		lowCnt_q == RESET_CYC + 60 |-> !memActive;
	endproperty
	a_wireReset: assert property (p_wireReset)
		else $error("long low did not leave memory phase");
	property p_rxHold;
		rxValid && !rxReady |=> rxValid && $stable(rxByte);
	endproperty
	a_rxHold: assert property (p_rxHold)
		else $error("rx head changed before accepted");
	property p_txTake;
		txValid && txReady |=> !txReady;
	endproperty
	a_txTake: assert property (p_txTake)
		else $error("tx ready stayed high after a take");
	property p_crcOk;
		$past(arst_n) |-> romCrcOk == $past(expOk);
	endproperty
	a_crcOk: assert property (p_crcOk)
		else $error("rom crc flag wrong");
endmodule : swl_link_chk

bind swl_link swl_link_chk #(.RESET_CYC(RESET_CYC), .PRES_LOW_CYC(PRES_LOW_CYC)) u_chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .lineIn(lineIn), .lineOut(lineOut),
	.lineOe(lineOe), .romCode(romCode), .rxByte(rxByte), .rxValid(rxValid),
	.rxReady(rxReady), .txItem(txItem), .txValid(txValid), .txReady(txReady),
	.memActive(memActive), .resumeFlag(resumeFlag), .romCrcOk(romCrcOk));

// file: tb/swl_master_model.sv
// bus master model that owns the wire: reset pulses and bit slots
module swl_master_model #(
	parameter int RST_LOW  = 2200, // reset pulse, above the shortened detect
	parameter int PRES_SMP = 1300, // presence sample after release
	parameter int RST_HIGH = 1700, // wait + low + recovery
	parameter int W0_LOW   = 1260, // past the device sample point
	parameter int W1_LOW   = 40,
	parameter int RD_LOW   = 40,   // kept short
	parameter int RD_SMP   = 120,  // well before the device lets go
	parameter int SLOT     = 1330  // whole slot with recovery
) (
	input  wire logic sys_clk,
	input  wire logic lineLvl,
	output logic      masterPull
);
	timeunit 1ns;
	timeprecision 1ps;
	initial masterPull = 1'b0;
	// all changes land on falling edges
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : idle
	task automatic busReset(output logic present);
		masterPull = 1'b1;
		idle(RST_LOW);
		masterPull = 1'b0;
		idle(PRES_SMP);
		present = ~lineLvl;
		idle(RST_HIGH - PRES_SMP);
	endtask : busReset
	task automatic writeBit(input logic b);
		masterPull = 1'b1;
		idle(b ? W1_LOW : W0_LOW);
		masterPull = 1'b0;
		idle(SLOT - (b ? W1_LOW : W0_LOW));
	endtask : writeBit
	task automatic readBit(output logic b);
		masterPull = 1'b1;
		idle(RD_LOW);
		masterPull = 1'b0;
		idle(RD_SMP - RD_LOW);
		b = lineLvl;
		idle(SLOT - RD_SMP);
	endtask : readBit
	// pulse shorter than the fall filter, then a longer low inside the hold-off;
	// a full slot of idle follows so that a wrongly started slot would finish
	task automatic glitch();
		masterPull = 1'b1;
		idle(3);
		masterPull = 1'b0;
		idle(5);
		masterPull = 1'b1;
		idle(20);
		masterPull = 1'b0;
		idle(SLOT);
	endtask : glitch
	// bytes go out one bit per slot, lsb first
	task automatic writeByte(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			writeBit(d[i]);
	endtask : writeByte
	task automatic readBits(input int n, output logic [15:0] d);
		d = 16'h0000;
		for (int i = 0; i < n; i++)
			readBit(d[i]);
	endtask : readBits
endmodule : swl_master_model

// file: tb/test_swl_link.sv
// self-checking bench for the single wire slave link
module test_swl_link;
	timeunit 1ns;
	timeprecision 1ps;
	logic              sys_clk;
	logic              arst_n;
	logic              lineOut;
	logic              lineOe;
	logic              masterPull;
	logic              lineLvl;
	logic [63:0]       romCode;
	logic [7:0]        rxByte;
	logic              rxValid;
	logic              rxReady;
	swl_pkg::swl_tx_t  txItem;
	logic              txValid;
	logic              txReady;
	logic              memActive;
	logic              resumeFlag;
	logic              romCrcOk;
	int                n_mismatch = 0;
	int                n_compared = 0;
	int                seed = 22922;
	// open-drain wire: low whenever either side pulls
	assign lineLvl = ~masterPull & (lineOe ? lineOut : 1'b1);
	// shortened counts keep the run short
	swl_link #(.RESET_CYC(2000), .PRES_LOW_CYC(200)) dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .lineIn(lineLvl), .lineOut(lineOut),
		.lineOe(lineOe), .romCode(romCode), .rxByte(rxByte), .rxValid(rxValid),
		.rxReady(rxReady), .txItem(txItem), .txValid(txValid), .txReady(txReady),
		.memActive(memActive), .resumeFlag(resumeFlag), .romCrcOk(romCrcOk));
	swl_master_model master (.sys_clk(sys_clk), .lineLvl(lineLvl), .masterPull(masterPull));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			c = {1'b0, c[15:1]} ^ ((c[0] ^ d[i]) ? swl_pkg::CRC16_POLY : 16'h0000);
		return c;
	endfunction : crc16
	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++)
			c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
		return c;
	endfunction : crc8
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask : check
	task automatic complete_run;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	// hand one item over, then wait until it sits in the shifter
	task automatic sendItem(input swl_pkg::swl_tx_t it);
		int n;
		n = 0;
		txItem = it;
		txValid = 1'b1;
		while (txReady !== 1'b1 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 200) begin
			n_mismatch++;
			complete_run();
		end
		@(negedge sys_clk);
		txValid = 1'b0;
		while (txReady !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 400) begin
			n_mismatch++;
			complete_run();
		end
	endtask : sendItem
	// hang guard
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_mismatch++;
		complete_run();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic        pres;
		logic [15:0] rd;
		logic [15:0] crc;
		logic [7:0]  wb;
		logic [7:0]  tb;
		arst_n = 1'b0;
		rxReady = 1'b0;
		txValid = 1'b0;
		txItem = '0;
		romCode = {$random(seed), $random(seed)};
		romCode[63:56] = crc8(romCode[55:0]);
		wb = 8'($random(seed));
		tb = 8'($random(seed));
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		arst_n = 1'b1;
		@(negedge sys_clk);
		check(16'(romCrcOk), 16'h0001, "rom crc flag");
		master.busReset(pres);
		check(16'(pres), 16'h0001, "presence seen");
		master.writeByte(swl_pkg::CMD_SKIP);
		check(16'(memActive), 16'h0001, "skip enters memory phase");
		check(16'(resumeFlag), 16'h0000, "flag after skip");
		master.glitch();
		master.writeByte(wb);
		check(16'(rxValid), 16'h0001, "rx byte ready");
		check(16'(rxByte), 16'(wb), "rx byte value");
		rxReady = 1'b1;
		@(negedge sys_clk);
		rxReady = 1'b0;
		@(negedge sys_clk);
		check(16'(rxValid), 16'h0000, "rx buffer drained");
		sendItem({1'b0, tb});
		master.readBits(8, rd);
		check(16'(rd[7:0]), 16'(tb), "read byte");
		crc = crc16(crc16(swl_pkg::CRC16_INIT, wb), tb);
		sendItem({1'b1, 8'h00});
		master.readBits(16, rd);
		check(rd, ~crc, "inverted crc16");
		master.busReset(pres);
		check(16'(pres), 16'h0001, "second presence");
		check(16'(memActive), 16'h0000, "reset leaves memory phase");
		master.writeByte(swl_pkg::CMD_RESUME);
		check(16'(memActive), 16'h0000, "resume refused without flag");
		check(16'(resumeFlag), 16'h0000, "flag still clear");
		master.busReset(pres);
		check(16'(pres), 16'h0001, "third presence");
		master.writeByte(swl_pkg::CMD_SEARCH);
		master.readBits(2, rd);
		check(rd, {14'h0000, ~romCode[0], romCode[0]}, "search bit and complement");
		master.writeBit(~romCode[0]);
		master.readBits(2, rd);
		check(rd, 16'h0003, "device left the search");
		check(16'(resumeFlag), 16'h0000, "flag after dropout");
		check(16'(memActive), 16'h0000, "no memory phase after dropout");
		romCode[63:56] = ~romCode[63:56];
		repeat (2) @(negedge sys_clk);
		check(16'(romCrcOk), 16'h0000, "bad rom crc seen");
		complete_run();
	end
endmodule : test_swl_link
